//--- include/simd_exec_pkg.sv
// Package for the packed-vector execution datapath: operation codes,
// immediate field positions, rounding modes and the request/response carriers.
// Assumes the issue logic fills a request in one cycle and reads the answer later.
package simd_exec_pkg;

  localparam int VEC_BITS = 128;
  localparam int VEC_BYTES = 16;
  localparam int SCALAR_BITS = 64;
  localparam int ADDR_LSB_BITS = 4;
  localparam int PIPE_LATENCY = 1;

  // Rounding modes as carried by the immediate and by the persistent setting
  localparam logic [1:0] RND_NEAREST = 2'h0;
  localparam logic [1:0] RND_DOWN = 2'h1;
  localparam logic [1:0] RND_UP = 2'h2;
  localparam logic [1:0] RND_TRUNC = 2'h3;

  // Immediate field positions
  localparam int IMM_RND_LSB = 0;
  localparam int IMM_RND_USE_CFG = 2;
  localparam int IMM_SUPPRESS_INEXACT = 3;
  localparam int IMM_INS_ZMASK_LSB = 0;
  localparam int IMM_INS_DST_LSB = 4;
  localparam int IMM_INS_SRC_LSB = 6;

  typedef enum logic [5:0] {
    op_idle,
    imm_blend_single, imm_blend_double, imm_blend_word,
    var_blend_single, var_blend_double, var_blend_byte,
    min_unsigned_word, min_unsigned_dword, min_signed_byte, min_signed_dword,
    max_unsigned_word, max_unsigned_dword, max_signed_byte, max_signed_dword,
    round_packed_single, round_packed_double, round_scalar_single, round_scalar_double,
    float_element_extract, float_element_insert,
    int_insert_byte, int_insert_dword, int_insert_qword,
    int_extract_byte, int_extract_word, int_extract_dword, int_extract_qword,
    sext_byte_to_word, zext_byte_to_word, sext_byte_to_dword, zext_byte_to_dword,
    sext_word_to_dword, zext_word_to_dword, sext_byte_to_qword, zext_byte_to_qword,
    sext_word_to_qword, zext_word_to_qword, sext_dword_to_qword, zext_dword_to_qword
  } op_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic use_mem;
    logic [ADDR_LSB_BITS-1:0] mem_addr;
    logic [7:0] immediate_control_byte;
    logic [VEC_BITS-1:0] src;
    logic [VEC_BITS-1:0] dst;
    logic [VEC_BITS-1:0] implicit_selector_vector;
    logic [SCALAR_BITS-1:0] gpr_in;
  } req_t;

  typedef struct packed {
    logic valid;
    logic align_fault;
    logic vec_we;
    logic [VEC_BITS-1:0] vec;
    logic gpr_we;
    logic store_we;
    logic [SCALAR_BITS-1:0] scalar;
    logic inexact;
  } resp_t;

  localparam resp_t RESP_RESET = '0;

endpackage

//--- design/simd_blend_minmax_round_convert.sv
// Packed-vector execution datapath: blend, integer min/max, float rounding,
// element insert/extract and packed widening conversions.
// Assumes the issue logic supplies register and memory operands already read;
// a memory operand arrives in src, its low address bits in mem_addr.
//
// Function
// RULE1: Blend keeps every element in its position
// RULE2: Variable blends steer from implicit selector vector
// RULE3: Selector field sign bit set picks source
// RULE4: Immediate bit i steers element i
// RULE5: Dword min/max, signed and unsigned forms
// RULE6: Signed byte, unsigned word min/max
// RULE7: Rounding in scalar and packed, both precisions
// RULE8: Immediate picks one of four modes
// RULE9: Immediate bit forces configured rounding mode
// RULE10: Immediate bit suppresses inexact exception
// RULE11: Float extract any dword to GPR/memory
// RULE12: Float insert from memory or vector element
// RULE13: Float insert zero mask writes positive zero
// RULE14: Integer insert byte/dword/qword into element
// RULE15: Integer extract byte/word/dword/qword outward
// RULE16: Insert/extract unaligned unless alignment checking
// RULE17: Widening conversions sign or zero extend
// RULE18: Widening source register or memory, vector destination
// RULE19: Element counts eight, four, two
// RULE20: Checked widening memory reference must be aligned
`timescale 1ns/1ns
`default_nettype none

module simd_blend_minmax_round_convert
#(
  parameter int VEC_W = 128
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire simd_exec_pkg::req_t req,
  input wire logic align_check_en,
  input wire logic [1:0] round_mode_cfg,
  output var simd_exec_pkg::resp_t resp
);
  import simd_exec_pkg::*;

  // The element arithmetic below is written for one fixed vector width
  if (VEC_W != VEC_BITS)
  begin : g_width_check
    $error("VEC_W must equal the package vector width");
  end

  resp_t resp_r;
  resp_t resp_nxt;

  // Per-byte select: one control bit per element of eb bytes
  function automatic logic [127:0] lane_pick(input logic [127:0] s, input logic [127:0] d,
                                             input logic [15:0] pick, input int eb);
    logic [127:0] r;
    r = '0;
    for (int b = 0; b < VEC_BYTES; b++)
    begin
      r[b*8 +: 8] = pick[b/eb] ? s[b*8 +: 8] : d[b*8 +: 8];
    end
    return r;
  endfunction

  // Sign bit of each eb-byte field of the selector
  function automatic logic [15:0] sign_bits(input logic [127:0] v, input int eb);
    logic [15:0] m;
    m = '0;
    for (int i = 0; i < VEC_BYTES; i++)
    begin
      if (i < VEC_BYTES/eb)
      begin
        m[i] = v[(i+1)*eb*8-1];
      end
    end
    return m;
  endfunction

  function automatic logic [127:0] min_max(input logic [127:0] a, input logic [127:0] b,
                                           input int eb, input logic sgn, input logic mx);
    logic [127:0] r;
    logic [31:0] x, y, msk, flip;
    logic take_x;
    int w;
    r = '0;
    w = eb*8;
    msk = 32'hFFFFFFFF >> (32-w);
    flip = sgn ? (32'h1 << (w-1)) : 32'h0;
    for (int i = 0; i < VEC_BYTES; i++)
    begin
      if (i < VEC_BYTES/eb)
      begin
        x = 32'(a >> (i*w)) & msk;
        y = 32'(b >> (i*w)) & msk;
        // Offset-binary trick turns a signed compare into an unsigned one
        take_x = mx ? ((x ^ flip) > (y ^ flip)) : ((x ^ flip) < (y ^ flip));
        r = r | (128'(take_x ? x : y) << (i*w));
      end
    end
    return r;
  endfunction

  // Widen the low elements of v from sb to db bytes
  function automatic logic [127:0] widen(input logic [127:0] v, input int sb, input int db,
                                         input logic sgn);
    logic [127:0] r;
    logic [63:0] e, smask, dmask;
    r = '0;
    smask = 64'hFFFFFFFFFFFFFFFF >> (64-sb*8);
    dmask = 64'hFFFFFFFFFFFFFFFF >> (64-db*8);
    for (int i = 0; i < VEC_BYTES; i++)
    begin
      if (i < VEC_BYTES/db)
      begin
        e = 64'(v >> (i*sb*8)) & smask;
        if (sgn && e[sb*8-1])
        begin
          e = e | ~smask;
        end
        r = r | (128'(e & dmask) << (i*db*8));
      end
    end
    return r;
  endfunction

  function automatic logic [127:0] put_elem(input logic [127:0] v, input logic [63:0] val,
                                            input int idx, input int eb);
    logic [127:0] m;
    m = 128'(64'hFFFFFFFFFFFFFFFF >> (64-eb*8)) << (idx*eb*8);
    return (v & ~m) | ((128'(val) << (idx*eb*8)) & m);
  endfunction

  function automatic logic [63:0] get_elem(input logic [127:0] v, input int idx, input int eb);
    return 64'(v >> (idx*eb*8)) & (64'hFFFFFFFFFFFFFFFF >> (64-eb*8));
  endfunction

  // Round to integral value; result in [63:0], inexact in [64]
  function automatic logic [64:0] fround(input logic [63:0] x, input logic dbl,
                                         input logic [1:0] mode);
    logic sign, up, inx;
    logic [63:0] mag, fmask, fr, half, res;
    int ex, bias, mb, emax, f;
    sign = dbl ? x[63] : x[31];
    mag = dbl ? {1'b0, x[62:0]} : {33'h0, x[30:0]};
    ex = dbl ? int'(x[62:52]) : int'(x[30:23]);
    bias = dbl ? 1023 : 127;
    mb = dbl ? 52 : 23;
    emax = dbl ? 2047 : 255;
    up = 1'b0;
    inx = 1'b0;
    if (ex == emax)
    begin
      // Infinity passes; a NaN comes back quieted
      mag = ((mag & ((64'h1 << mb) - 64'h1)) != 64'h0) ? (mag | (64'h1 << (mb-1))) : mag;
    end
    else if (ex < bias)
    begin
      inx = (mag != 64'h0);
      unique case (mode)
        RND_NEAREST: up = (ex == bias-1) && (mag > (64'(bias-1) << mb));
        RND_DOWN: up = sign && inx;
        RND_UP: up = !sign && inx;
        RND_TRUNC: up = 1'b0;
      endcase
      mag = up ? (64'(bias) << mb) : 64'h0;
    end
    else if (ex < bias+mb)
    begin
      f = bias+mb-ex;
      fmask = (64'h1 << f) - 64'h1;
      fr = mag & fmask;
      half = 64'h1 << (f-1);
      inx = (fr != 64'h0);
      unique case (mode)
        RND_NEAREST: up = (fr > half) || ((fr == half) && mag[f]);
        RND_DOWN: up = sign && inx;
        RND_UP: up = !sign && inx;
        RND_TRUNC: up = 1'b0;
      endcase
      // A carry out of the mantissa bumps the exponent, which is correct
      mag = (mag & ~fmask) + (up ? (64'h1 << f) : 64'h0);
    end
    res = dbl ? {sign, mag[62:0]} : {32'h0, sign, mag[30:0]};
    return {inx, res};
  endfunction

  // Memory reference width in bytes, for the alignment check
  function automatic int ref_bytes(input op_t op);
    unique case (op)
      int_insert_byte, int_extract_byte: return 1;
      int_extract_word, sext_byte_to_qword, zext_byte_to_qword: return 2;
      float_element_extract, float_element_insert, int_insert_dword, int_extract_dword,
      sext_byte_to_dword, zext_byte_to_dword, sext_word_to_qword, zext_word_to_qword:
        return 4;
      default: return 8;
    endcase
  endfunction

  always_comb
  begin
    logic [7:0] imm;
    logic [1:0] rmode;
    logic [64:0] rr;
    logic inx_any;
    logic [63:0] fval;
    logic [127:0] ins;
    logic mem_check;
    imm = req.immediate_control_byte;
    rmode = '0;
    rr = '0;
    inx_any = 1'b0;
    fval = '0;
    ins = '0;
    resp_nxt = RESP_RESET;
    resp_nxt.valid = req.valid;
    mem_check = 1'b0;
    if (req.valid)
    begin
      // RULE9: configured mode overrides
      rmode = imm[IMM_RND_USE_CFG] ? round_mode_cfg : imm[IMM_RND_LSB +: 2];
      resp_nxt.vec_we = 1'b1;
      unique case (req.op)
        // RULE1: per-position pick
        // RULE4: immediate bit per element
        imm_blend_single: resp_nxt.vec = lane_pick(req.src, req.dst, {12'h0, imm[3:0]}, 4);
        imm_blend_double: resp_nxt.vec = lane_pick(req.src, req.dst, {14'h0, imm[1:0]}, 8);
        imm_blend_word: resp_nxt.vec = lane_pick(req.src, req.dst, {8'h0, imm}, 2);
        // RULE2: selector register controls
        // RULE3: field sign bit picks source
        var_blend_single: resp_nxt.vec = lane_pick(req.src, req.dst,
                                          sign_bits(req.implicit_selector_vector, 4), 4);
        var_blend_double: resp_nxt.vec = lane_pick(req.src, req.dst,
                                          sign_bits(req.implicit_selector_vector, 8), 8);
        var_blend_byte: resp_nxt.vec = lane_pick(req.src, req.dst,
                                          sign_bits(req.implicit_selector_vector, 1), 1);
        // RULE6: unsigned word, signed byte
        min_unsigned_word: resp_nxt.vec = min_max(req.dst, req.src, 2, 1'b0, 1'b0);
        max_unsigned_word: resp_nxt.vec = min_max(req.dst, req.src, 2, 1'b0, 1'b1);
        min_signed_byte: resp_nxt.vec = min_max(req.dst, req.src, 1, 1'b1, 1'b0);
        max_signed_byte: resp_nxt.vec = min_max(req.dst, req.src, 1, 1'b1, 1'b1);
        // RULE5: dword both signednesses
        min_unsigned_dword: resp_nxt.vec = min_max(req.dst, req.src, 4, 1'b0, 1'b0);
        max_unsigned_dword: resp_nxt.vec = min_max(req.dst, req.src, 4, 1'b0, 1'b1);
        min_signed_dword: resp_nxt.vec = min_max(req.dst, req.src, 4, 1'b1, 1'b0);
        max_signed_dword: resp_nxt.vec = min_max(req.dst, req.src, 4, 1'b1, 1'b1);
        // RULE7: packed and scalar, both precisions
        // RULE8: mode from immediate, setting untouched
        round_packed_single:
        begin
          for (int i = 0; i < 4; i++)
          begin
            rr = fround({32'h0, req.src[i*32 +: 32]}, 1'b0, rmode);
            resp_nxt.vec[i*32 +: 32] = rr[31:0];
            inx_any = inx_any | rr[64];
          end
        end
        round_packed_double:
        begin
          for (int i = 0; i < 2; i++)
          begin
            rr = fround(req.src[i*64 +: 64], 1'b1, rmode);
            resp_nxt.vec[i*64 +: 64] = rr[63:0];
            inx_any = inx_any | rr[64];
          end
        end
        round_scalar_single:
        begin
          rr = fround({32'h0, req.src[31:0]}, 1'b0, rmode);
          resp_nxt.vec = {req.dst[127:32], rr[31:0]};
          inx_any = rr[64];
        end
        round_scalar_double:
        begin
          rr = fround(req.src[63:0], 1'b1, rmode);
          resp_nxt.vec = {req.dst[127:64], rr[63:0]};
          inx_any = rr[64];
        end
        // RULE11: any dword outward
        // RULE15: element out, zero extended
        float_element_extract, int_extract_byte, int_extract_word, int_extract_dword,
          int_extract_qword:
        begin
          // A memory operand takes the result instead of a general register
          resp_nxt.vec_we = 1'b0;
          resp_nxt.store_we = req.use_mem;
          resp_nxt.gpr_we = !req.use_mem;
          mem_check = 1'b1;
          resp_nxt.scalar = get_elem(req.src, int'(imm[3:0]) % (VEC_BYTES / ref_bytes(req.op)),
                                     ref_bytes(req.op));
        end
        // RULE12: memory word or chosen element
        float_element_insert:
        begin
          fval = req.use_mem ? {32'h0, req.src[31:0]}
                             : get_elem(req.src, int'(imm[IMM_INS_SRC_LSB +: 2]), 4);
          ins = put_elem(req.dst, fval, int'(imm[IMM_INS_DST_LSB +: 2]), 4);
          // RULE13: masked elements become +0.0
          for (int i = 0; i < 4; i++)
          begin
            if (imm[IMM_INS_ZMASK_LSB + i])
            begin
              ins[i*32 +: 32] = 32'h0;
            end
          end
          resp_nxt.vec = ins;
          mem_check = 1'b1;
        end
        // RULE14: scalar into chosen element
        int_insert_byte, int_insert_dword, int_insert_qword:
        begin
          resp_nxt.vec = put_elem(req.dst, req.use_mem ? req.src[63:0] : req.gpr_in,
                                  int'(imm[3:0]) % (VEC_BYTES / ref_bytes(req.op)),
                                  ref_bytes(req.op));
          mem_check = 1'b1;
        end
        // RULE17: sign or zero extension
        // RULE18: result always to vector
        // RULE19: counts follow destination width
        sext_byte_to_word: resp_nxt.vec = widen(req.src, 1, 2, 1'b1);
        zext_byte_to_word: resp_nxt.vec = widen(req.src, 1, 2, 1'b0);
        sext_byte_to_dword: resp_nxt.vec = widen(req.src, 1, 4, 1'b1);
        zext_byte_to_dword: resp_nxt.vec = widen(req.src, 1, 4, 1'b0);
        sext_word_to_dword: resp_nxt.vec = widen(req.src, 2, 4, 1'b1);
        zext_word_to_dword: resp_nxt.vec = widen(req.src, 2, 4, 1'b0);
        sext_byte_to_qword: resp_nxt.vec = widen(req.src, 1, 8, 1'b1);
        zext_byte_to_qword: resp_nxt.vec = widen(req.src, 1, 8, 1'b0);
        sext_word_to_qword: resp_nxt.vec = widen(req.src, 2, 8, 1'b1);
        zext_word_to_qword: resp_nxt.vec = widen(req.src, 2, 8, 1'b0);
        sext_dword_to_qword: resp_nxt.vec = widen(req.src, 4, 8, 1'b1);
        zext_dword_to_qword: resp_nxt.vec = widen(req.src, 4, 8, 1'b0);
        default: resp_nxt.vec_we = 1'b0;
      endcase
      // RULE10: inexact suppressible
      resp_nxt.inexact = inx_any && !imm[IMM_SUPPRESS_INEXACT];
      mem_check = mem_check || (req.op inside {[sext_byte_to_word:zext_dword_to_qword]});
      // RULE16: unaligned fine unless checking on
      // RULE20: checked reference must be aligned
      if (mem_check && req.use_mem && align_check_en &&
          ((int'(req.mem_addr) % ref_bytes(req.op)) != 0))
      begin
        // A faulting operation commits nothing
        resp_nxt.align_fault = 1'b1;
        resp_nxt.vec_we = 1'b0;
        resp_nxt.gpr_we = 1'b0;
        resp_nxt.store_we = 1'b0;
        resp_nxt.inexact = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_r <= RESP_RESET;
    end
    else
    begin
      resp_r <= resp_nxt;
    end
  end

  assign resp = resp_r;

endmodule // simd_blend_minmax_round_convert

`default_nettype wire

//--- testbench/simd_exec_properties.sv
// Checker for the packed-vector datapath, watching only its top-level ports.
// Assumes one request per valid cycle and the fixed one-cycle answer.
`timescale 1ns/1ns
`default_nettype none
module simd_exec_properties
  import simd_exec_pkg::*;
#(
  parameter int VEC_W = 128
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire simd_exec_pkg::req_t req,
  input wire logic align_check_en,
  input wire logic [1:0] round_mode_cfg,
  input wire simd_exec_pkg::resp_t resp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_blend_writes: assert property (
    req.valid && req.op inside {[imm_blend_single:var_blend_byte]}
    |=> resp.valid && resp.vec_we && !resp.gpr_we && !resp.align_fault)
    else $error("blend answer missing or wrong kind");
  a_minmax_writes: assert property (
    req.valid && req.op inside {[min_unsigned_word:max_signed_dword]}
    |=> resp.valid && resp.vec_we && !resp.store_we && !resp.align_fault)
    else $error("min/max answer missing or wrong kind");
  a_fault_quiet: assert property (
    resp.align_fault |-> resp.valid && !resp.vec_we && !resp.gpr_we && !resp.store_we
    && !resp.inexact)
    else $error("faulting answer still writes");
  a_round_quiet: assert property (
    req.valid && req.op inside {[round_packed_single:round_scalar_double]}
    && req.immediate_control_byte[3] |=> resp.vec_we && !resp.inexact)
    else $error("inexact reported although suppressed");
  a_extract_route: assert property (
    req.valid && !align_check_en
    && req.op inside {float_element_extract, [int_extract_byte:int_extract_qword]}
    |=> resp.store_we == $past(req.use_mem) && resp.gpr_we != $past(req.use_mem)
    && !resp.vec_we)
    else $error("extract result sent to the wrong place");
  a_unaligned_ok: assert property (
    req.valid && !align_check_en
    && req.op inside {[float_element_extract:int_extract_qword]}
    |=> resp.valid && !resp.align_fault)
    else $error("insert or extract faulted without checking");
  a_widen_fault: assert property (
    req.valid && req.op inside {[sext_byte_to_word:zext_dword_to_qword]}
    && req.use_mem && align_check_en && req.mem_addr[0] |=> resp.align_fault)
    else $error("odd widening reference did not fault");
  a_widen_reg: assert property (
    req.valid && req.op inside {[sext_byte_to_word:zext_dword_to_qword]} && !req.use_mem
    |=> resp.vec_we && !resp.align_fault && !resp.gpr_we && !resp.store_we)
    else $error("widening did not write a vector");
  a_extract_zext: assert property (
    req.valid && req.op == int_extract_byte && !align_check_en
    |=> resp.gpr_we && resp.scalar[63:8] == 56'h0 && resp.scalar[7:0] == $past(
    req.src[req.immediate_control_byte[3:0]*8 +: 8]))
    else $error("byte extract value or extension wrong");
endmodule // simd_exec_properties

bind simd_blend_minmax_round_convert simd_exec_properties #(.VEC_W(VEC_W))
  u_simd_exec_properties (.clk(clk), .rst_n(rst_n), .req(req),
  .align_check_en(align_check_en), .round_mode_cfg(round_mode_cfg), .resp(resp));
`default_nettype wire

//--- testbench/issue_model.sv
// Issue-side model: presents one request per call and hands back the answer.
// Assumes the datapath answers exactly one cycle after taking a request.
`timescale 1ns/1ns
`default_nettype none
module issue_model
  import simd_exec_pkg::*;
(
  input wire logic clk,
  output var simd_exec_pkg::req_t req,
  input wire simd_exec_pkg::resp_t resp
);
  initial req = '0;
  task automatic issue(input op_t op, input logic [7:0] imm, input logic [127:0] s, d, sel,
                       input logic [63:0] g, input logic um, input logic [3:0] a,
                       output resp_t r);
    @(posedge clk);
    req <= '{1'b1, op, um, a, imm, s, d, sel, g};
    @(posedge clk);
    // Withdrawn lines show inverted data so stale operands cannot pass
    req <= {1'b0, ~req[$bits(req_t) - 2:0]};
    #1 r = resp;
  endtask
endmodule // issue_model
`default_nettype wire

//--- testbench/simd_blend_minmax_round_convert_test.sv
// Self-checking bench for the packed-vector datapath: table-driven request calls.
// Assumes the issue model answers each call after the one-cycle latency.
`timescale 1ns/1ns
`default_nettype none
module simd_blend_minmax_round_convert_test;
  import simd_exec_pkg::*;
  localparam logic [127:0] A = 128'h8001_7FFE_00FF_FF00_1234_8765_F00F_0FF0;
  localparam logic [127:0] B = 128'h7FFF_8000_FF01_00FE_8765_1234_0FF0_F00F;
  localparam logic [127:0] SEL = 128'h8F00_7F80_FF01_0080_00FF_8000_7FFF_C0DE;
  localparam logic [63:0] G = 64'h1122_3344_5566_77AB;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic align_check_en = 1'b0;
  logic [1:0] round_mode_cfg = 2'h0;
  req_t req;
  resp_t resp;
  resp_t r;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [127:0] e;
  logic [15:0] pk;
  int eb, sb, db, w;
  int ebt[6] = '{32, 64, 16, 32, 64, 8};
  int sbt[6] = '{8, 8, 16, 8, 16, 32};
  int dbt[6] = '{16, 32, 32, 64, 64, 64};
  int xi[4] = '{15, 7, 1, 1};
  always #5 clk = ~clk;

  simd_blend_minmax_round_convert u_simd_blend_minmax_round_convert (.clk(clk),
    .rst_n(rst_n), .req(req), .align_check_en(align_check_en),
    .round_mode_cfg(round_mode_cfg), .resp(resp));
  issue_model u_issue_model (.clk(clk), .req(req), .resp(resp));

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [127:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic chk_fl(input string n, input logic f, v, g, st, x);
    check(n, 128'({r.valid, r.align_fault, r.vec_we, r.gpr_we, r.store_we, r.inexact}),
          128'({1'b1, f, v, g, st, x}));
  endtask
  task automatic run(input op_t op, input logic [7:0] imm, input logic [127:0] s,
                     input logic um, input logic [3:0] a);
    u_issue_model.issue(op, imm, s, B, SEL, G, um, a, r);
  endtask
  task automatic setcfg(input logic ac, input logic [1:0] rm);
    @(posedge clk);
    align_check_en <= ac;
    round_mode_cfg <= rm;
  endtask
  function automatic logic [127:0] m(input int n);
    return (128'h1 << n) - 128'h1;
  endfunction
  // Source A, destination B throughout
  function automatic logic [127:0] mm(input int eb, input logic sg, mx);
    logic [127:0] o, x, y, t;
    o = '0;
    t = 128'(sg) << (eb - 1);
    for (int i = 0; i < 128 / eb; i++)
    begin
      x = (B >> (i * eb)) & m(eb);
      y = (A >> (i * eb)) & m(eb);
      o |= ((((x ^ t) < (y ^ t)) != mx) ? x : y) << (i * eb);
    end
    return o;
  endfunction
  function automatic logic [127:0] bl(input int eb, input logic [15:0] pk);
    logic [127:0] o;
    o = '0;
    for (int i = 0; i < 128 / eb; i++)
      o |= (((pk[i] ? A : B) >> (i * eb)) & m(eb)) << (i * eb);
    return o;
  endfunction
  function automatic logic [127:0] wd(input int sb, db, input logic sg);
    logic [127:0] o, x;
    o = '0;
    for (int i = 0; i < 128 / db; i++)
    begin
      x = (A >> (i * sb)) & m(sb);
      if (sg && x[sb - 1])
        x |= m(db) & ~m(sb);
      o |= x << (i * db);
    end
    return o;
  endfunction

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      eb = ebt[k];
      pk = 16'h00A5;
      if (k > 2)
        for (int i = 0; i < 16; i++)
          pk[i] = SEL[(i * eb + eb - 1) % 128];
      run(op_t'(k + 1), 8'hA5, A, 1'b0, 4'h0);
      check("blend", r.vec, bl(eb, pk));
    end
    for (int k = 0; k < 8; k++)
    begin
      run(op_t'(k + 7), 8'h00, A, 1'b0, 4'h0);
      check("minmax", r.vec, mm(ebt[(k % 4 + 2) % 6 / 2 * 0 + ((k % 4) == 0 ? 2 : (k % 4) == 2 ? 5 : 0)], k % 4 > 1, k > 3));
    end
    for (int k = 0; k < 8; k++)
    begin
      setcfg(1'b0, 2'((k < 4) ? (k ^ 1) : k));
      run(round_packed_single, 8'((k < 4) ? k : 4), {4{32'h3FC0_0000}}, 1'b0, 4'h0);
      check("round mode", r.vec, {4{(k % 2) ? 32'h3F80_0000 : 32'h4000_0000}});
      chk_fl("round flags", 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    end
    run(round_packed_single, 8'h08, {4{32'h3FC0_0000}}, 1'b0, 4'h0);
    chk_fl("round quiet", 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    run(round_scalar_double, 8'h00, {A[127:64], 64'h4004_0000_0000_0000}, 1'b0, 4'h0);
    check("round sd", r.vec, {B[127:64], 64'h4000_0000_0000_0000});
    run(round_packed_double, 8'h03, {2{64'hBFF8_0000_0000_0000}}, 1'b0, 4'h0);
    check("round pd", r.vec, {2{64'hBFF0_0000_0000_0000}});
    run(round_scalar_single, 8'h02, {A[127:32], 32'h3FC0_0000}, 1'b0, 4'h0);
    check("round ss", r.vec, {B[127:32], 32'h4000_0000});
    run(float_element_extract, 8'h02, A, 1'b0, 4'h0);
    check("fext", 128'(r.scalar), {96'h0, A[95:64]});
    chk_fl("fext gpr", 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    run(float_element_extract, 8'h02, A, 1'b1, 4'h3);
    chk_fl("fext mem", 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    run(float_element_insert, 8'hD1, A, 1'b0, 4'h0);
    check("fins", r.vec, {B[127:64], A[127:96], 32'h0});
    run(float_element_insert, 8'h50, A, 1'b1, 4'h2);
    check("fins mem", r.vec, {B[127:64], A[31:0], B[31:0]});
    run(int_insert_byte, 8'h05, A, 1'b0, 4'h0);
    check("ins b", r.vec, {B[127:48], 8'hAB, B[39:0]});
    run(int_insert_dword, 8'h03, A, 1'b0, 4'h0);
    check("ins d", r.vec, {G[31:0], B[95:0]});
    for (int k = 0; k < 4; k++)
    begin
      eb = 8 << k;
      run(op_t'(k + 24), 8'(xi[k]), A, 1'b0, 4'h0);
      check("extract", 128'(r.scalar), (A >> (xi[k] * eb)) & m(eb));
    end
    setcfg(1'b1, 2'h0);
    run(int_insert_qword, 8'h01, A, 1'b1, 4'h8);
    check("ins q", r.vec, {A[63:0], B[63:0]});
    run(int_insert_qword, 8'h01, A, 1'b1, 4'h4);
    chk_fl("ins q fault", 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    run(int_extract_dword, 8'h01, A, 1'b1, 4'h1);
    chk_fl("ext d fault", 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 12; k++)
    begin
      sb = sbt[k / 2];
      db = dbt[k / 2];
      w = sb * (128 / db) / 8;
      e = wd(sb, db, k % 2 == 0);
      run(op_t'(k + 28), 8'h00, A, 1'b0, 4'h0);
      check("widen", r.vec, e);
      run(op_t'(k + 28), 8'h00, A, 1'b1, 4'(w / 2));
      chk_fl("widen fault", 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      run(op_t'(k + 28), 8'h00, A, 1'b1, 4'(w));
      check("widen mem", r.vec, e);
    end
    results;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results;
  end
endmodule // simd_blend_minmax_round_convert_test
`default_nettype wire
